// ### bench/dbcs_top_sva.sv
// Bus handshake and bit-clock pulse checks for the clock select block
`timescale 1ns/1ns
module dbcs_top_sva (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Register bus
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // Bit clocks
  input wire tx_a_bit_en,
  input wire rx_b_bit_en
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  property p_b_answer; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid; endproperty
  a_b_answer: assert property (p_b_answer) else $error("no write response");
  property p_r_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_answer: assert property (p_r_answer) else $error("no read response");
  property p_ar_refuse; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_refuse: assert property (p_ar_refuse) else $error("read address taken while busy");
  property p_w_refuse; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_w_refuse: assert property (p_w_refuse) else $error("write taken while busy");
  property p_unmapped; s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h20 |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0000_0000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  property p_tx_a_pulse; tx_a_bit_en |=> !tx_a_bit_en; endproperty
  a_tx_a_pulse: assert property (p_tx_a_pulse) else $error("tx A bit clock too wide");
  property p_rx_b_pulse; $rose(rx_b_bit_en) |=> $fell(rx_b_bit_en); endproperty
  a_rx_b_pulse: assert property (p_rx_b_pulse) else $error("rx B bit clock too wide");
  // Main scenarios reached
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
  c_tx_a: cover property (tx_a_bit_en);
  c_rx_b: cover property (rx_b_bit_en);
endmodule // dbcs_top_sva
bind dbcs_top dbcs_top_sva u_sva (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .tx_a_bit_en(tx_a_bit_en), .rx_b_bit_en(rx_b_bit_en));

// ### bench/dbcs_top_tb_top.sv
// Self-checking bench for the dual channel bit-clock select block
`timescale 1ns/1ns
`include "dbcs_map.vh"
module dbcs_top_tb_top;
  logic aclk = 0, aresetn = 0, ref_clk_en = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 0, pins = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire output_pin_3, rx_a_bit_en, tx_a_bit_en, rx_b_bit_en, tx_b_bit_en;
  wire rx_a_sample_en, rx_b_sample_en;
  logic rx_a = 1, rx_b = 1;
  int fails = 0, samples_checked = 0, cyc = 0, rc = 0;
  int last [7], prev [7];
  logic op3_q = 0;
  wire [6:0] ev = {rx_b_sample_en, rx_a_sample_en, output_pin_3 !== op3_q, tx_b_bit_en,
    rx_b_bit_en, tx_a_bit_en, rx_a_bit_en};
  dbcs_top dut (.aclk(aclk), .aresetn(aresetn), .ref_clk_en(ref_clk_en),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .input_pin_2(pins[0]),
    .input_pin_3(pins[1]), .input_pin_4(pins[2]), .input_pin_5(pins[3]), .rx_data_a(rx_a),
    .rx_data_b(rx_b), .output_pin_3(output_pin_3), .rx_a_bit_en(rx_a_bit_en),
    .tx_a_bit_en(tx_a_bit_en), .rx_b_bit_en(rx_b_bit_en), .tx_b_bit_en(tx_b_bit_en),
    .rx_a_sample_en(rx_a_sample_en), .rx_b_sample_en(rx_b_sample_en));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock, reference pulse every 13 cycles, event time stamps
  initial begin
    forever #10 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    rc <= (rc == 12) ? 0 : rc + 1;
    ref_clk_en <= (rc == 12);
    cyc <= cyc + 1;
    op3_q <= output_pin_3;
    for (int i = 0; i < 7; i++) begin
      if (ev[i] === 1'b1) begin
        prev[i] <= last[i];
        last[i] <= cyc;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Compare and verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Register bus write, both items offered together
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw, w;
    aw = 1;
    w = 1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_wstrb <= 4'h1;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (aw && s_axi_awready) begin aw = 0; s_axi_awvalid <= 0; end
      if (w && s_axi_wready) begin w = 0; s_axi_wvalid <= 0; end
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 0;
    chk({30'h0, s_axi_bresp}, {30'h0, `DBCS_RESP_OKAY});
  endtask
  // Register bus read with expected data and response
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 0;
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  task automatic gap(input int i, input int e);
    chk(32'(last[i] - prev[i]), 32'(e));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    rd(`DBCS_OFF_AUX, 32'h0000_0000, 2'b00);
    rd(`DBCS_OFF_PRE_LO, 32'h0000_0002, 2'b00);
    rd(`DBCS_OFF_STATUS, 32'h0000_0000, 2'b00);
    rd(8'h24, 32'h0000_0000, `DBCS_RESP_SLVERR);
  endtask
  task automatic t_extend;
    logic [7:0] ad [7] = '{8'h00, 8'h00, 8'h04, 8'h04, 8'h00, 8'h04, 8'h00};
    logic [7:0] dt [7] = '{8'h0A, 8'h08, 8'h0A, 8'h08, 8'h09, 8'h0B, 8'h19};
    logic [7:0] st [7] = '{8'h02, 8'h03, 8'h0B, 8'h0F, 8'h0E, 8'h06, 8'h06};
    for (int i = 0; i < 7; i++) begin
      wr(ad[i], dt[i]);
      rd(`DBCS_OFF_STATUS, {24'h0, st[i]}, 2'b00);
    end
    wr(`DBCS_OFF_CMD_A, 8'h08);
  endtask
  task automatic t_brg;
    wr(`DBCS_OFF_AUX, 8'h80);
    rd(`DBCS_OFF_AUX, 32'h0000_0080, 2'b00);
    wr(`DBCS_OFF_CSEL_A, 8'h88);
    repeat (1300) @(posedge aclk);
    gap(0, 416);
    gap(1, 416);
  endtask
  task automatic t_timer;
    wr(`DBCS_OFF_PRE_UP, 8'h00);
    wr(`DBCS_OFF_PRE_LO, 8'h02);
    wr(`DBCS_OFF_AUX, 8'hE0);
    // Read before the first toggle: wave still low, extends A rx, A tx, B rx set
    rd(`DBCS_OFF_STATUS, 32'h0000_0017, 2'b00);
    wr(`DBCS_OFF_CSEL_B, 8'hDD);
    wr(`DBCS_OFF_OPCFG, 8'h04);
    repeat (2000) @(posedge aclk);
    gap(4, 26);
    gap(2, 832);
    gap(3, 832);
    wr(`DBCS_OFF_OPCFG, 8'h00);
    repeat (60) @(posedge aclk);
    chk({31'h0, output_pin_3}, 32'h0000_0000);
  endtask
  task automatic t_pins;
    wr(`DBCS_OFF_CSEL_A, 8'hFF);
    wr(`DBCS_OFF_CSEL_B, 8'hEE);
    // Binary count: each pin rises at its own rate, so a swapped pin shows
    for (int i = 0; i < 800; i++) begin
      repeat (4) @(posedge aclk);
      pins <= pins + 4'h1;
    end
    repeat (8) @(posedge aclk);
    gap(0, 32);
    gap(1, 16);
    gap(2, 128);
    gap(3, 1024);
    gap(5, 32);
  endtask
  // Start bit on both receivers: midpoint at seventh 16X tick, then every sixteen
  task automatic t_rx;
    int t0;
    wr(`DBCS_OFF_CSEL_A, 8'h88);
    wr(`DBCS_OFF_CSEL_B, 8'h88);
    @(posedge aclk);
    t0 = cyc;
    rx_a <= 0;
    rx_b <= 0;
    repeat (200) @(posedge aclk);
    rx_a <= 1;
    rx_b <= 1;
    repeat (500) @(posedge aclk);
    chk(32'(prev[5] - t0 >= 158 && prev[5] - t0 <= 183), 32'h1);
    chk(32'(prev[6] - t0 >= 158 && prev[6] - t0 <= 183), 32'h1);
    gap(5, 416);
    gap(6, 416);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    t_reset;
    t_extend;
    t_brg;
    t_timer;
    t_pins;
    t_rx;
    conclude;
  end
  initial begin
    #400000;
    fails++;
    conclude;
  end
endmodule // dbcs_top_tb_top

// ### design/dbcs_map.vh
// Register offsets, field positions, command codes and clock-select codes
`ifndef DBCS_MAP_VH
`define DBCS_MAP_VH
// Register byte addresses
`define DBCS_OFF_CMD_A 8'h00
`define DBCS_OFF_CMD_B 8'h04
`define DBCS_OFF_AUX 8'h08
`define DBCS_OFF_CSEL_A 8'h0C
`define DBCS_OFF_CSEL_B 8'h10
`define DBCS_OFF_PRE_UP 8'h14
`define DBCS_OFF_PRE_LO 8'h18
`define DBCS_OFF_OPCFG 8'h1C
`define DBCS_OFF_STATUS 8'h20
// Command codes
`define DBCS_CMD_RX_SET 4'h8
`define DBCS_CMD_RX_CLR 4'h9
`define DBCS_CMD_TX_SET 4'hA
`define DBCS_CMD_TX_CLR 4'hB
// Auxiliary control fields
`define DBCS_AUX_SET_BIT 7
`define DBCS_AUX_MODE_HI 6
`define DBCS_AUX_MODE_LO 4
`define DBCS_CT_TIMER_XCLK 3'b110
// Output pin configuration field
`define DBCS_OP3_HI 3
`define DBCS_OP3_LO 2
`define DBCS_OP3_TIMER 2'b01
// Clock-select codes
`define DBCS_CS_BRG_MAX 4'hC
`define DBCS_CS_TIMER 4'hD
`define DBCS_CS_EXT16 4'hE
`define DBCS_CS_EXT1 4'hF
// Reset values
`define DBCS_RST_BYTE 8'h00
`define DBCS_RST_PRELOAD 16'h0002
// Oversampling and start-bit midpoint
`define DBCS_OVERSAMPLE 5'd16
`define DBCS_MID_COUNT 4'h7
// AXI responses
`define DBCS_RESP_OKAY 2'b00
`define DBCS_RESP_SLVERR 2'b10
`endif

// ### design/dbcs_top.v
// Dual channel bit-clock source selection with AXI4-Lite registers
//
// Overview of operation
// - Command code 0x0A sets the channel transmitter extend bit.
// - Command code 0x08 sets the channel receiver extend bit.
// - Auxiliary control bit 7 picks rate set two when high.
// - Both extends, set two, select 0x88 give 115.2 kbps both directions.
// - Timer square wave equals source frequency over twice the 16-bit preload.
// - Mode field 110 runs timer mode clocked from the reference clock.
// - Select nibble 0xD takes timer output as 16X, divided by sixteen.
// - Output configuration bits 3:2 equal 01 drive timer wave on output pin 3.
// - Channel A select 0xFF: transmitter input pin 3, receiver input pin 4, 1X.
// - Code 0x09 clears receiver extend, code 0x0B clears transmitter extend.
// - Select nibbles 0x0 to 0xC choose the baud rate generator.
// - 16X receiver takes seventh period after start as midpoint, then every 16.
//
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ns
`include "dbcs_map.vh"

module dbcs_top #(
  parameter REF_DIV_16X_0 = 16'd2,
  parameter BRG_SHIFT_MAX = 4'd15
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Reference clock enable, one pulse per reference period
  input wire ref_clk_en,
  // AXI4-Lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // General purpose inputs used as clocks
  input wire input_pin_2,
  input wire input_pin_3,
  input wire input_pin_4,
  input wire input_pin_5,
  // Receiver serial data for midpoint tracking
  input wire rx_data_a,
  input wire rx_data_b,
  // Outputs
  output reg output_pin_3,
  output reg rx_a_bit_en,
  output reg tx_a_bit_en,
  output reg rx_b_bit_en,
  output reg tx_b_bit_en,
  output reg rx_a_sample_en,
  output reg rx_b_sample_en
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg [7:0] auxiliary_control;
  reg [7:0] channel_a_clock_select;
  reg [7:0] channel_b_clock_select;
  reg [7:0] timer_preload_upper;
  reg [7:0] timer_preload_lower;
  reg [7:0] output_pin_configuration;
  reg rx_ext_a, tx_ext_a, rx_ext_b, tx_ext_b;
  localparam [15:0] RST_PRELOAD = `DBCS_RST_PRELOAD;
  reg [7:0] aw_addr;
  reg aw_full;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_full;

  // Write channel capture, either order
  assign s_axi_awready = !aw_full && !s_axi_bvalid;
  assign s_axi_wready = !w_full && !s_axi_bvalid;
  wire wr_go = aw_full && w_full && !s_axi_bvalid;
  wire wr_lane = w_strb[0];

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DBCS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped(aw_addr) ? `DBCS_RESP_OKAY : `DBCS_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Address decode shared by write and read
  function wr_mapped;
    input [7:0] a;
    begin
      wr_mapped = (a <= `DBCS_OFF_STATUS) && (a[1:0] == 2'b00);
    end
  endfunction

  // Register writes and extend-bit commands
  always @(posedge aclk) begin
    if (!aresetn) begin
      auxiliary_control <= `DBCS_RST_BYTE;
      channel_a_clock_select <= `DBCS_RST_BYTE;
      channel_b_clock_select <= `DBCS_RST_BYTE;
      timer_preload_upper <= RST_PRELOAD[15:8];
      timer_preload_lower <= RST_PRELOAD[7:0];
      output_pin_configuration <= `DBCS_RST_BYTE;
      rx_ext_a <= 1'b0;
      tx_ext_a <= 1'b0;
      rx_ext_b <= 1'b0;
      tx_ext_b <= 1'b0;
    end else if (wr_go && wr_lane) begin
      case (aw_addr)
        `DBCS_OFF_CMD_A: begin
          if (w_data[7:4] == 4'h0) begin
            case (w_data[3:0])
              `DBCS_CMD_RX_SET: rx_ext_a <= 1'b1;
              `DBCS_CMD_RX_CLR: rx_ext_a <= 1'b0;
              `DBCS_CMD_TX_SET: tx_ext_a <= 1'b1;
              `DBCS_CMD_TX_CLR: tx_ext_a <= 1'b0;
              default: ;
            endcase
          end
        end
        `DBCS_OFF_CMD_B: begin
          if (w_data[7:4] == 4'h0) begin
            case (w_data[3:0])
              `DBCS_CMD_RX_SET: rx_ext_b <= 1'b1;
              `DBCS_CMD_RX_CLR: rx_ext_b <= 1'b0;
              `DBCS_CMD_TX_SET: tx_ext_b <= 1'b1;
              `DBCS_CMD_TX_CLR: tx_ext_b <= 1'b0;
              default: ;
            endcase
          end
        end
        `DBCS_OFF_AUX: auxiliary_control <= w_data[7:0];
        `DBCS_OFF_CSEL_A: channel_a_clock_select <= w_data[7:0];
        `DBCS_OFF_CSEL_B: channel_b_clock_select <= w_data[7:0];
        `DBCS_OFF_PRE_UP: timer_preload_upper <= w_data[7:0];
        `DBCS_OFF_PRE_LO: timer_preload_lower <= w_data[7:0];
        `DBCS_OFF_OPCFG: output_pin_configuration <= w_data[7:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Baud rate generator: 16X enable from a divisor per code
  // Divisor in reference periods for the 16X rate, per set and extend
  function [15:0] brg_div;
    input [3:0] code;
    input set2;
    input ext;
    reg [15:0] d;
    begin
      d = 16'd0;
      case ({ext, set2, code})
        6'b110_000 + 6'd8: d = REF_DIV_16X_0;
        default: d = 16'd2 << (BRG_SHIFT_MAX - {1'b0, code[2:0]} - 4'd8 + {3'b000, code[3]});
      endcase
      if (!ext) d = d << 1;
      if (!set2) d = d + (d >> 1);
      brg_div = d;
    end
  endfunction

  // Per-direction divider counters running on reference enables
  reg [15:0] brg_cnt [0:3];
  reg [3:0] brg_tick;
  wire [3:0] sel_code [0:3];
  wire [3:0] sel_ext;
  assign sel_code[0] = channel_a_clock_select[7:4];
  assign sel_code[1] = channel_a_clock_select[3:0];
  assign sel_code[2] = channel_b_clock_select[7:4];
  assign sel_code[3] = channel_b_clock_select[3:0];
  assign sel_ext = {tx_ext_b, rx_ext_b, tx_ext_a, rx_ext_a};
  // One loop index per process
  integer i, j, k, m;

  // Each direction counts its own divisor, selected set from bit 7
  always @(posedge aclk) begin
    if (!aresetn) begin
      for (i = 0; i < 4; i = i + 1) brg_cnt[i] <= 16'h0000;
      brg_tick <= 4'h0;
    end else begin
      for (i = 0; i < 4; i = i + 1) begin
        brg_tick[i] <= 1'b0;
        if (ref_clk_en) begin
          if (brg_cnt[i] + 16'd1 >= brg_div(sel_code[i],
              auxiliary_control[`DBCS_AUX_SET_BIT], sel_ext[i])) begin
            brg_cnt[i] <= 16'h0000;
            brg_tick[i] <= 1'b1;
          end else begin
            brg_cnt[i] <= brg_cnt[i] + 16'd1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter/timer square wave
  wire [15:0] preload = {timer_preload_upper, timer_preload_lower};
  wire timer_mode = auxiliary_control[`DBCS_AUX_MODE_HI:`DBCS_AUX_MODE_LO] == `DBCS_CT_TIMER_XCLK;
  reg [15:0] ct_cnt;
  reg ct_wave;

  // Toggles every preload reference periods: period is twice the preload
  always @(posedge aclk) begin
    if (!aresetn) begin
      ct_cnt <= 16'h0000;
      ct_wave <= 1'b0;
    end else if (!timer_mode) begin
      ct_cnt <= 16'h0000;
    end else if (ref_clk_en) begin
      if (ct_cnt + 16'd1 >= preload) begin
        ct_cnt <= 16'h0000;
        ct_wave <= ~ct_wave;
      end else begin
        ct_cnt <= ct_cnt + 16'd1;
      end
    end
  end

  // Timer output onto output pin 3, else held low
  always @(posedge aclk) begin
    if (!aresetn) output_pin_3 <= 1'b0;
    else output_pin_3 <= (output_pin_configuration[`DBCS_OP3_HI:`DBCS_OP3_LO]
                          == `DBCS_OP3_TIMER) ? ct_wave : 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Synchronise pins and timer, detect rising edges
  reg [3:0] pin_s1, pin_s2, pin_s3;
  reg ct_d;
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
      pin_s3 <= 4'h0;
      ct_d <= 1'b0;
    end else begin
      // Order: rx A = pin 4, tx A = pin 3, rx B = pin 2, tx B = pin 5
      pin_s1 <= {input_pin_5, input_pin_2, input_pin_3, input_pin_4};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      ct_d <= ct_wave;
    end
  end
  wire [3:0] pin_rise = pin_s2 & ~pin_s3;
  wire ct_rise = ct_wave & ~ct_d;

  // Per-direction 16X pulse and divide-by-sixteen
  reg [3:0] x16_pulse, x1_pulse;
  reg [3:0] div_cnt [0:3];
  reg [3:0] bit_en;
  always @* begin
    for (j = 0; j < 4; j = j + 1) begin
      x16_pulse[j] = 1'b0;
      x1_pulse[j] = 1'b0;
      if (sel_code[j] <= `DBCS_CS_BRG_MAX) x16_pulse[j] = brg_tick[j];
      else if (sel_code[j] == `DBCS_CS_TIMER) x16_pulse[j] = ct_rise;
      else if (sel_code[j] == `DBCS_CS_EXT16) x16_pulse[j] = pin_rise[j];
      else x1_pulse[j] = pin_rise[j];
    end
  end

  // Divide 16X sources by sixteen; 1X passes through
  always @(posedge aclk) begin
    if (!aresetn) begin
      for (k = 0; k < 4; k = k + 1) div_cnt[k] <= 4'h0;
      bit_en <= 4'h0;
    end else begin
      for (k = 0; k < 4; k = k + 1) begin
        bit_en[k] <= x1_pulse[k];
        if (x16_pulse[k]) begin
          div_cnt[k] <= div_cnt[k] + 4'h1;
          if (div_cnt[k] == 4'hF) bit_en[k] <= 1'b1;
        end
      end
    end
  end

  always @* begin
    rx_a_bit_en = bit_en[0];
    tx_a_bit_en = bit_en[1];
    rx_b_bit_en = bit_en[2];
    tx_b_bit_en = bit_en[3];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver midpoint sampling per channel
  localparam ST_IDLE = 2'd0;
  localparam ST_START = 2'd1;
  localparam ST_DATA = 2'd2;
  reg [1:0] rx_st [0:1];
  reg [3:0] rx_cnt [0:1];
  reg [3:0] rx_bits [0:1];
  reg [1:0] rx_smp;
  wire [1:0] rx_din = {rx_data_b, rx_data_a};
  wire [1:0] rx_x16 = {x16_pulse[2], x16_pulse[0]};
  wire [1:0] rx_x1 = {x1_pulse[2], x1_pulse[0]};

  // Seventh 16X period marks midpoint, then every sixteen; 1X samples each
  always @(posedge aclk) begin
    if (!aresetn) begin
      for (m = 0; m < 2; m = m + 1) begin
        rx_st[m] <= ST_IDLE;
        rx_cnt[m] <= 4'h0;
        rx_bits[m] <= 4'h0;
      end
      rx_smp <= 2'b00;
    end else begin
      for (m = 0; m < 2; m = m + 1) begin
        rx_smp[m] <= rx_x1[m];
        if (rx_x16[m]) begin
          case (rx_st[m])
            ST_IDLE: if (!rx_din[m]) begin
              rx_st[m] <= ST_START;
              rx_cnt[m] <= 4'h1;
            end
            ST_START: begin
              rx_cnt[m] <= rx_cnt[m] + 4'h1;
              if (rx_cnt[m] == `DBCS_MID_COUNT - 4'h1) begin
                rx_cnt[m] <= 4'h0;
                rx_bits[m] <= 4'h0;
                rx_smp[m] <= 1'b1;
                rx_st[m] <= rx_din[m] ? ST_IDLE : ST_DATA;
              end
            end
            ST_DATA: begin
              rx_cnt[m] <= rx_cnt[m] + 4'h1;
              if (rx_cnt[m] == 4'hF) begin
                rx_smp[m] <= 1'b1;
                rx_bits[m] <= rx_bits[m] + 4'h1;
                if (rx_bits[m] == 4'hA) rx_st[m] <= ST_IDLE;
              end
            end
            default: rx_st[m] <= ST_IDLE;
          endcase
        end
      end
    end
  end

  always @* begin
    rx_a_sample_en = rx_smp[0];
    rx_b_sample_en = rx_smp[1];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel
  assign s_axi_arready = !s_axi_rvalid;
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `DBCS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= wr_mapped(s_axi_araddr) ? `DBCS_RESP_OKAY : `DBCS_RESP_SLVERR;
      case (s_axi_araddr)
        `DBCS_OFF_AUX: s_axi_rdata <= {24'h00_0000, auxiliary_control};
        `DBCS_OFF_CSEL_A: s_axi_rdata <= {24'h00_0000, channel_a_clock_select};
        `DBCS_OFF_CSEL_B: s_axi_rdata <= {24'h00_0000, channel_b_clock_select};
        `DBCS_OFF_PRE_UP: s_axi_rdata <= {24'h00_0000, timer_preload_upper};
        `DBCS_OFF_PRE_LO: s_axi_rdata <= {24'h00_0000, timer_preload_lower};
        `DBCS_OFF_OPCFG: s_axi_rdata <= {24'h00_0000, output_pin_configuration};
        `DBCS_OFF_STATUS: s_axi_rdata <= {26'h000_0000, ct_wave, timer_mode,
                                          tx_ext_b, rx_ext_b, tx_ext_a, rx_ext_a};
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // dbcs_top
